// ### src/rsw_pkg.sv
// constants and types of the redundancy switch command interpreter
package rsw_pkg;
  // register byte addresses
  localparam logic [11:0] A_CMD   = 12'h000;
  localparam logic [11:0] A_ARG0  = 12'h004;
  localparam logic [11:0] A_ARG1  = 12'h008;
  localparam logic [11:0] A_STAT  = 12'h00C;
  localparam logic [11:0] A_ISTAT = 12'h010;
  localparam logic [11:0] A_IMASK = 12'h014;
  localparam logic [11:0] A_AMASK = 12'h018;
  localparam logic [11:0] A_ALARM = 12'h01C;
  localparam logic [11:0] A_RESP  = 12'h040;
  localparam int          RESP_N  = 19;
  // opcodes
  localparam logic [15:0] OP_ID    = 16'h2000;
  localparam logic [15:0] OP_VER   = 16'h2080;
  localparam logic [15:0] OP_FDEF  = 16'h2281;
  localparam logic [15:0] OP_CFG   = 16'h2083;
  localparam logic [15:0] OP_QMODE = 16'h2084;
  localparam logic [15:0] OP_SMODE = 16'h2284;
  localparam logic [15:0] OP_QSTAT = 16'h2085;
  localparam logic [15:0] OP_FORCE = 16'h2285;
  localparam logic [15:0] OP_QDLY  = 16'h2086;
  localparam logic [15:0] OP_SDLY  = 16'h2286;
  localparam logic [15:0] OP_QALM  = 16'h2087;
  localparam logic [15:0] OP_QMSK  = 16'h2089;
  // answer codes, factory default unlock bytes and the none state value
  localparam logic [7:0]  RC_GOOD  = 8'h00;
  localparam logic [7:0]  RC_BPAR  = 8'hFF;
  localparam logic [7:0]  RC_BOP   = 8'hFE;
  localparam logic [7:0]  UNLOCK1  = 8'h55;
  localparam logic [7:0]  UNLOCK2  = 8'hAA;
  localparam logic [7:0]  ST_NONE  = 8'h02;
  // identity and firmware, values arbitrary
  localparam logic [7:0]  DEV_ID   = 8'h5A;
  localparam logic [15:0] FW_VER   = 16'h0105;
  localparam logic [79:0] FW_NAME  = {"SWFW01", 32'h0000_0000};
  localparam logic [55:0] FW_DATE  = {"010100", 8'h00};
  // defaults
  localparam logic [15:0] DEF_DMF  = 16'h0002;
  localparam logic [15:0] DEF_DMN  = 16'h0002;
  localparam logic [15:0] DEF_DDF  = 16'h0032;
  localparam logic [15:0] DEF_DDN  = 16'h0032;
  localparam logic [7:0]  DEF_EMSK = 8'hFF;
  localparam logic [4:0]  DEF_SMSK = 5'h1F;
  // interrupt status bits
  localparam int IB_DONE = 0;
  localparam int IB_GLOB = 1;
  localparam int IB_SWCH = 2;
  // delay tick
  localparam int TICK_MS  = 20;
  localparam int CLK_KHZ  = 20000;
  localparam int TICK_CYC = CLK_KHZ * TICK_MS;
  typedef enum logic [1:0] {
    CS_IDLE = 2'b00,
    CS_EXEC = 2'b01,
    CS_DONE = 2'b11
  } rsw_cs_t;
endpackage

// ### src/rsw_flt_if.sv
// bundle between the interpreter and one fault delay filter
`timescale 1ns/1ns
interface rsw_flt_if;
  logic        raw;
  logic        tick;
  logic [15:0] dly_f;
  logic [15:0] dly_n;
  logic        fault;
  modport ctl (output raw, tick, dly_f, dly_n, input fault);
  modport flt (input raw, tick, dly_f, dly_n, output fault);
endinterface

// ### src/rsw_sync3.sv
// three-stage pin synchroniser, change taken when stages two and three agree
`timescale 1ns/1ns
module rsw_sync3 #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // pins and result
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
    end else begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // s1 feeds only s2; per bit the output moves once s2 and s3 agree
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dout <= '0;
    end else begin
      dout <= (~(s2 ^ s3) & s3) | ((s2 ^ s3) & dout);
    end
  end
endmodule

// ### src/rsw_dly_flt.sv
// fault persistence filter counting delay ticks in both directions
`timescale 1ns/1ns
module rsw_dly_flt (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // filter bundle
  rsw_flt_if.flt    f
);
  logic [15:0] cnt;
  logic        state;

  assign f.fault = state;

  // a fault counts against the fault delay, recovery against the other;
  // a bounce back to the current state restarts the count
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= 1'b0;
      cnt   <= 16'h0000;
    end else if (f.raw == state) begin
      cnt <= 16'h0000;
    end else if (cnt >= (f.raw ? f.dly_f : f.dly_n)) begin
      state <= f.raw;
      cnt   <= 16'h0000;
    end else if (f.tick) begin
      cnt <= cnt + 16'h0001;
    end
  end
endmodule

// ### src/rsw_top.sv
// redundancy switch command interpreter with apb register access
// Behaviour
// - device id query answers one byte, the fixed identification code
// - version query answers 19 bytes: version, 10-byte name, 7-byte date
// - factory defaults need unlock bytes 0x55 then 0xAA, then restore
// - mode set 0 manual 1 automatic; query same, only ever 0 or 1
// - state query answers mod then demod: 0 A, 1 B, 2 none
// - force backup takes mod then demod byte, 0 A or 1 B online
// - delay query answers four 16-bit delays, high byte first
// - delay set takes the same four delays in the same layout
// - alarm query answers global, external, switch and two zero bytes
// - global alarm byte carries the alarm on bit 0, rest zero
// - external byte: mod, forced mod, demod, forced demod; A then B
// - switch byte: power 1, power 2, firmware, memory, internal; 5-7 zero
// - mask query answers external mask, switch mask, two zero bytes
// - external mask bit enables the external alarm at the same position
// - switch mask bits 0-4 enable switch alarms; bits 5-7 read zero
// - delays count 20 ms ticks; fault and recovery must persist
`timescale 1ns/1ns
module rsw_top #(
  parameter int TICK_CYCLES = rsw_pkg::TICK_CYC
) (
  // clock and reset
  input  wire logic        CLK,
  input  wire logic        RSTN,
  // apb slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  input  wire logic [3:0]  PSTRB,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // alarm and strap pins
  input  wire logic [3:0]  UNIT_FAULT,
  input  wire logic [3:0]  FORCE_ALARM,
  input  wire logic [4:0]  SWITCH_ALARM,
  input  wire logic [1:0]  BACKUP_CFG,
  // switch outputs
  output logic             MOD_SEL_B,
  output logic             DMD_SEL_B,
  output logic             GLOBAL_ALARM,
  output logic             IRQ
);
  logic [14:0]          pins;
  logic [3:0]           fault;
  logic [31:0]          tick_cnt;
  logic                 tick;
  rsw_pkg::rsw_cs_t     cs;
  logic [15:0]          opcode;
  logic [63:0]          args;
  logic [7:0]           rcode;
  logic [7:0]           rlen;
  logic [7:0]           resp [0:rsw_pkg::RESP_N-1];
  logic                 mode_auto;
  logic                 mod_b;
  logic                 dmd_b;
  logic [15:0]          dly [0:3];
  logic [7:0]           emask;
  logic [4:0]           smask;
  logic [7:0]           ext_alm;
  logic [4:0]           sw_alm;
  logic                 glob;
  logic                 glob_q;
  logic [2:0]           istat;
  logic [2:0]           imask;
  logic                 wr_acc;
  logic                 rd_setup;
  logic                 unmapped;
  logic [31:0]          rd_val;
  logic [151:0]         next_blob;
  logic [7:0]           next_len;
  logic [7:0]           next_code;
  logic                 cmd_ok;
  logic                 sel_chg;
  logic [1:0]           sel_q;

  function automatic logic [7:0] argb(input logic [63:0] a,
                                      input int i);
    return a[8*i +: 8];
  endfunction

  function automatic logic [31:0] wmerge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0]  strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction

  // pins and fault filters
  rsw_sync3 #(.W(15)) u_sync (
    .clk   (CLK),
    .rst_n (RSTN),
    .din   ({BACKUP_CFG, SWITCH_ALARM, FORCE_ALARM, UNIT_FAULT}),
    .dout  (pins)
  );

  // one tick every 20 ms shared by all four filters
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      tick_cnt <= 32'h0000_0000;
      tick     <= 1'b0;
    end else if (tick_cnt >= 32'(TICK_CYCLES - 1)) begin
      tick_cnt <= 32'h0000_0000;
      tick     <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 32'h0000_0001;
      tick     <= 1'b0;
    end
  end

  // filter order: mod A, demod A, mod B, demod B; mod uses dly 0/1
  for (genvar g = 0; g < 4; g++) begin : g_flt
    rsw_flt_if fi ();
    assign fi.raw   = pins[g];
    assign fi.tick  = tick;
    assign fi.dly_f = dly[(g % 2) * 2];
    assign fi.dly_n = dly[(g % 2) * 2 + 1];
    assign fault[g] = fi.fault;
    rsw_dly_flt u_flt (
      .clk   (CLK),
      .rst_n (RSTN),
      .f     (fi.flt)
    );
  end

  // alarms
  always_comb begin
    ext_alm = {pins[7], pins[3], pins[6], pins[2],
               pins[5], pins[1], pins[4], pins[0]};
    ext_alm[0] = fault[0];
    ext_alm[2] = fault[1];
    ext_alm[4] = fault[2];
    ext_alm[6] = fault[3];
    sw_alm = pins[12:8];
    glob = |(ext_alm & emask) | |(sw_alm & smask);
  end

  assign GLOBAL_ALARM = glob_q;
  assign MOD_SEL_B    = mod_b;
  assign DMD_SEL_B    = dmd_b;

  // apb
  assign PREADY   = 1'b1;
  assign wr_acc   = PSEL && PENABLE && PWRITE;
  assign rd_setup = PSEL && !PENABLE && !PWRITE;
  assign PSLVERR  = PSEL && PENABLE && unmapped;

  always_comb begin
    rd_val   = 32'h0000_0000;
    unmapped = 1'b0;
    if (PADDR == rsw_pkg::A_CMD) begin
      rd_val = {16'h0000, opcode};
    end else if (PADDR == rsw_pkg::A_ARG0) begin
      rd_val = args[31:0];
    end else if (PADDR == rsw_pkg::A_ARG1) begin
      rd_val = args[63:32];
    end else if (PADDR == rsw_pkg::A_STAT) begin
      rd_val = {15'h0000, cs != rsw_pkg::CS_IDLE, rlen, rcode};
    end else if (PADDR == rsw_pkg::A_ISTAT) begin
      rd_val = {29'h0000_0000, istat};
    end else if (PADDR == rsw_pkg::A_IMASK) begin
      rd_val = {29'h0000_0000, imask};
    end else if (PADDR == rsw_pkg::A_AMASK) begin
      rd_val = {19'h0_0000, smask, emask};
    end else if (PADDR == rsw_pkg::A_ALARM) begin
      rd_val = {11'h000, sw_alm, ext_alm, 7'h00, glob_q};
    end else if (PADDR >= rsw_pkg::A_RESP && PADDR[1:0] == 2'b00 &&
                 PADDR < rsw_pkg::A_RESP + 12'(4 * rsw_pkg::RESP_N)) begin
      rd_val = {24'h00_0000, resp[5'(PADDR[11:2] - 10'h010)]};
    end else begin
      unmapped = 1'b1;
    end
  end

  // read data captured in the setup cycle so it comes from a flip-flop
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      PRDATA <= 32'h0000_0000;
    end else if (rd_setup) begin
      PRDATA <= rd_val;
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      args <= 64'h0;
    end else if (wr_acc && PADDR == rsw_pkg::A_ARG0) begin
      args[31:0] <= wmerge(args[31:0], PWDATA, PSTRB);
    end else if (wr_acc && PADDR == rsw_pkg::A_ARG1) begin
      args[63:32] <= wmerge(args[63:32], PWDATA, PSTRB);
    end
  end

  // command sequencer
  // a new opcode is refused while one is in flight
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      cs     <= rsw_pkg::CS_IDLE;
      opcode <= 16'h0000;
    end else begin
      case (cs)
        rsw_pkg::CS_IDLE: begin
          if (wr_acc && PADDR == rsw_pkg::A_CMD) begin
            opcode <= PWDATA[15:0];
            cs     <= rsw_pkg::CS_EXEC;
          end
        end
        rsw_pkg::CS_EXEC: cs <= rsw_pkg::CS_DONE;
        default:          cs <= rsw_pkg::CS_IDLE;
      endcase
    end
  end

  // answer bytes are packed first byte high in a 19-byte blob
  always_comb begin
    next_blob = 152'h0;
    next_len  = 8'h00;
    next_code = rsw_pkg::RC_GOOD;
    case (opcode)
      rsw_pkg::OP_ID: begin
        next_blob[151:144] = rsw_pkg::DEV_ID;
        next_len = 8'd1;
      end
      rsw_pkg::OP_VER: begin
        next_blob = {rsw_pkg::FW_VER, rsw_pkg::FW_NAME,
                     rsw_pkg::FW_DATE};
        next_len = 8'd19;
      end
      rsw_pkg::OP_FDEF: begin
        if (argb(args, 0) != rsw_pkg::UNLOCK1 ||
            argb(args, 1) != rsw_pkg::UNLOCK2) begin
          next_code = rsw_pkg::RC_BPAR;
        end
      end
      rsw_pkg::OP_CFG: begin
        next_blob[151:144] = {6'h00, pins[14:13]};
        next_len = 8'd1;
      end
      rsw_pkg::OP_QMODE: begin
        next_blob[151:144] = {7'h00, mode_auto};
        next_len = 8'd1;
      end
      rsw_pkg::OP_SMODE: begin
        if (argb(args, 0) > 8'h01) begin
          next_code = rsw_pkg::RC_BPAR;
        end
      end
      rsw_pkg::OP_QSTAT: begin
        // a path outside the strapped backup reports none
        next_blob[151:144] = (pins[14:13] == 2'd2) ? rsw_pkg::ST_NONE
                             : {7'h00, mod_b};
        next_blob[143:136] = (pins[14:13] == 2'd1) ? rsw_pkg::ST_NONE
                             : {7'h00, dmd_b};
        next_len = 8'd2;
      end
      rsw_pkg::OP_FORCE: begin
        if (argb(args, 0) > 8'h01 || argb(args, 1) > 8'h01) begin
          next_code = rsw_pkg::RC_BPAR;
        end
      end
      rsw_pkg::OP_QDLY: begin
        next_blob[151:88] = {dly[0], dly[1], dly[2], dly[3]};
        next_len = 8'd8;
      end
      rsw_pkg::OP_SDLY: begin
        next_len = 8'd0;
      end
      rsw_pkg::OP_QALM: begin
        next_blob[151:112] = {7'h00, glob_q, ext_alm,
                              3'h0, sw_alm, 16'h0000};
        next_len = 8'd5;
      end
      rsw_pkg::OP_QMSK: begin
        next_blob[151:120] = {emask, 3'h0, smask, 16'h0000};
        next_len = 8'd4;
      end
      default: next_code = rsw_pkg::RC_BOP;
    endcase
  end

  assign cmd_ok = (cs == rsw_pkg::CS_EXEC) && (next_code == rsw_pkg::RC_GOOD);

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      rcode <= rsw_pkg::RC_GOOD;
      rlen  <= 8'h00;
      for (int i = 0; i < rsw_pkg::RESP_N; i++) begin
        resp[i] <= 8'h00;
      end
    end else if (cs == rsw_pkg::CS_EXEC) begin
      rcode <= next_code;
      rlen  <= (next_code == rsw_pkg::RC_GOOD) ? next_len : 8'h00;
      for (int i = 0; i < rsw_pkg::RESP_N; i++) begin
        resp[i] <= next_blob[151 - 8*i -: 8];
      end
    end
  end

  // settings
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      mode_auto <= 1'b0;
    end else if (cmd_ok && opcode == rsw_pkg::OP_FDEF) begin
      mode_auto <= 1'b0;
    end else if (cmd_ok && opcode == rsw_pkg::OP_SMODE) begin
      mode_auto <= args[0];
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      dly[0] <= rsw_pkg::DEF_DMF;
      dly[1] <= rsw_pkg::DEF_DMN;
      dly[2] <= rsw_pkg::DEF_DDF;
      dly[3] <= rsw_pkg::DEF_DDN;
    end else if (cmd_ok && opcode == rsw_pkg::OP_FDEF) begin
      dly[0] <= rsw_pkg::DEF_DMF;
      dly[1] <= rsw_pkg::DEF_DMN;
      dly[2] <= rsw_pkg::DEF_DDF;
      dly[3] <= rsw_pkg::DEF_DDN;
    end else if (cmd_ok && opcode == rsw_pkg::OP_SDLY) begin
      for (int k = 0; k < 4; k++) begin
        dly[k] <= {argb(args, 2*k), argb(args, 2*k + 1)};
      end
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      emask <= rsw_pkg::DEF_EMSK;
      smask <= rsw_pkg::DEF_SMSK;
    end else if (cmd_ok && opcode == rsw_pkg::OP_FDEF) begin
      emask <= rsw_pkg::DEF_EMSK;
      smask <= rsw_pkg::DEF_SMSK;
    end else if (wr_acc && PADDR == rsw_pkg::A_AMASK) begin
      if (PSTRB[0]) begin
        emask <= PWDATA[7:0];
      end
      if (PSTRB[1]) begin
        smask <= PWDATA[12:8];
      end
    end
  end

  // online selection: commands first, then automatic changeover that
  // moves away from a true fault only if the standby unit is healthy;
  // coupled backup moves both paths together
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      mod_b <= 1'b0;
      dmd_b <= 1'b0;
    end else if (cmd_ok && opcode == rsw_pkg::OP_FDEF) begin
      mod_b <= 1'b0;
      dmd_b <= 1'b0;
    end else if (cmd_ok && opcode == rsw_pkg::OP_FORCE) begin
      mod_b <= args[0];
      dmd_b <= args[8];
    end else if (mode_auto) begin
      if (pins[14:13] == 2'd0) begin
        if (!mod_b && (fault[0] || fault[1]) && !fault[2] && !fault[3]) begin
          mod_b <= 1'b1;
          dmd_b <= 1'b1;
        end else if (mod_b && (fault[2] || fault[3]) &&
                     !fault[0] && !fault[1]) begin
          mod_b <= 1'b0;
          dmd_b <= 1'b0;
        end
      end else begin
        if (pins[14:13] != 2'd2 && fault[{mod_b, 1'b0}] &&
            !fault[{!mod_b, 1'b0}]) begin
          mod_b <= !mod_b;
        end
        if (pins[14:13] != 2'd1 && fault[{dmd_b, 1'b1}] &&
            !fault[{!dmd_b, 1'b1}]) begin
          dmd_b <= !dmd_b;
        end
      end
    end
  end

  // interrupts
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      glob_q <= 1'b0;
      imask  <= 3'h0;
      sel_q  <= 2'h0;
    end else begin
      glob_q <= glob;
      sel_q  <= {mod_b, dmd_b};
      if (wr_acc && PADDR == rsw_pkg::A_IMASK && PSTRB[0]) begin
        imask <= PWDATA[2:0];
      end
    end
  end

  // the select outputs follow mod_b and dmd_b directly, so compare with last cycle
  assign sel_chg = ({mod_b, dmd_b} != sel_q);

  // an event in the clearing cycle survives: set wins over clear
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      istat <= 3'h0;
    end else begin
      for (int e = 0; e < 3; e++) begin
        if ((e == rsw_pkg::IB_DONE && cs == rsw_pkg::CS_DONE) ||
            (e == rsw_pkg::IB_GLOB && glob && !glob_q) ||
            (e == rsw_pkg::IB_SWCH && sel_chg)) begin
          istat[e] <= 1'b1;
        end else if (wr_acc && PADDR == rsw_pkg::A_ISTAT &&
                     PSTRB[0] && PWDATA[e]) begin
          istat[e] <= 1'b0;
        end
      end
    end
  end

  assign IRQ = |(istat & imask);
endmodule

// ### tb/rsw_checker.sv
// port assertions of the switch command interpreter
`timescale 1ns/1ns
module rsw_chk (
  // clock and reset
  input wire logic        CLK,
  input wire logic        RSTN,
  // apb
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  // alarm
  input wire logic        GLOBAL_ALARM
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RSTN);
  logic acc;
  logic alm_rd;
  assign acc = PSEL && PENABLE;
  assign alm_rd = acc && !PWRITE && PADDR == rsw_pkg::A_ALARM;
  ready_high_a: assert property (PREADY)
    else $error("pready low");
  err_idle_a: assert property (!acc |-> !PSLVERR)
    else $error("error outside access");
  err_hole_a: assert property (acc && PADDR == 12'h020 |-> PSLVERR)
    else $error("no error on unmapped address");
  err_mapped_a: assert property (alm_rd |-> !PSLVERR)
    else $error("error on mapped address");
  alarm_zero_a: assert property (
    alm_rd |-> PRDATA[7:1] == 7'h00 && PRDATA[23:21] == 3'h0)
    else $error("spare alarm bits set");
  // either capture point of the global bit agrees once the pin is steady
  alarm_glob_a: assert property (
    alm_rd && $stable(GLOBAL_ALARM) |-> PRDATA[0] == GLOBAL_ALARM)
    else $error("global alarm bit differs from pin");
  smask_zero_a: assert property (
    acc && !PWRITE && PADDR == rsw_pkg::A_AMASK |-> PRDATA[15:13] == 3'h0)
    else $error("switch mask spare bits set");
  rdata_hold_a: assert property (
    !(PSEL && !PENABLE && !PWRITE) |=> $stable(PRDATA))
    else $error("read data moved outside a read");
  alarm_c: cover property (alm_rd && PRDATA[0]);
  err_c: cover property (PSLVERR);
  rise_c: cover property ($rose(GLOBAL_ALARM));
endmodule
bind rsw_top rsw_chk u_chk (.CLK(CLK), .RSTN(RSTN), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA),
  .PREADY(PREADY), .PSLVERR(PSLVERR), .GLOBAL_ALARM(GLOBAL_ALARM));

// ### tb/rsw_host.sv
// apb master standing in for the monitor and control computer
`timescale 1ns/1ns
module rsw_host (
  // clock
  input  wire logic        clk,
  // apb master
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [11:0] paddr,
  output logic      [31:0] pwdata,
  output logic      [3:0]  pstrb,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'hF;
  end
  // idle edge first, so psel is never driven twice at one edge
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] r,
                      output logic e);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // released lines show the inverse, not a stale copy
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule

// ### tb/tb_top.sv
// self-checking bench of the switch command interpreter
`timescale 1ns/1ns
module tb_top;
  logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, e;
  logic        msel, dsel, galarm, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [3:0]  pstrb, uflt, fal;
  logic [4:0]  sal;
  logic [1:0]  cfg;
  int          n_mismatch, n_checks, cyc;
  rsw_top #(.TICK_CYCLES(4)) dut (.CLK(clk), .RSTN(rst_n), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PSTRB(pstrb), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .UNIT_FAULT(uflt), .FORCE_ALARM(fal), .SWITCH_ALARM(sal),
    .BACKUP_CFG(cfg), .MOD_SEL_B(msel), .DMD_SEL_B(dsel),
    .GLOBAL_ALARM(galarm), .IRQ(irq));
  rsw_host host (.clk(clk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));
  always #25 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, x);
    n_checks++;
    if (s !== x) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask
  task automatic rd(input logic [11:0] a);
    host.xfer(1'b0, a, 32'h0, r, e);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, r, e);
  endtask
  // arguments go before the opcode; busy is polled under a bound
  task automatic cmd(input logic [15:0] op, input logic [31:0] a0, a1,
                     input logic [7:0] rc, ln);
    int n;
    wr(rsw_pkg::A_ARG0, a0);
    wr(rsw_pkg::A_ARG1, a1);
    wr(rsw_pkg::A_CMD, {16'h0000, op});
    n = 0;
    do begin
      rd(rsw_pkg::A_STAT);
      n++;
    end while (r[16] !== 1'b0 && n < 10);
    chk(r[16:0], {1'b0, ln, rc});
  endtask
  task automatic rb(input int i, input logic [7:0] x);
    rd(12'(rsw_pkg::A_RESP + 4 * i));
    chk(r, {24'h0, x});
  endtask
  task automatic ext0(input int n, input logic x);
    repeat (n) @(posedge clk);
    rd(rsw_pkg::A_ALARM);
    chk(r[8], x);
  endtask
  task automatic t_query();
    logic [151:0] v;
    v = {rsw_pkg::FW_VER, rsw_pkg::FW_NAME, rsw_pkg::FW_DATE};
    cmd(rsw_pkg::OP_ID, 0, 0, rsw_pkg::RC_GOOD, 8'h01);
    rb(0, rsw_pkg::DEV_ID);
    cmd(16'h2999, 0, 0, rsw_pkg::RC_BOP, 8'h00);
    cmd(rsw_pkg::OP_VER, 0, 0, rsw_pkg::RC_GOOD, 8'h13);
    for (int i = 0; i < 19; i++) rb(i, v[151-8*i -: 8]);
    for (int c = 0; c < 4; c++) begin
      cfg <= 2'(c);
      repeat (6) @(posedge clk);
      cmd(rsw_pkg::OP_CFG, 0, 0, rsw_pkg::RC_GOOD, 8'h01);
      rb(0, 8'(c));
    end
  endtask
  task automatic t_set();
    for (int m = 2; m >= 0; m--) begin
      cmd(rsw_pkg::OP_SMODE, m, 0, m > 1 ? rsw_pkg::RC_BPAR :
          rsw_pkg::RC_GOOD, 8'h00);
      cmd(rsw_pkg::OP_QMODE, 0, 0, rsw_pkg::RC_GOOD, 8'h01);
      rb(0, m > 1 ? 8'h00 : 8'(m));
    end
    cmd(rsw_pkg::OP_SDLY, 32'h04030201, 32'h08070605,
        rsw_pkg::RC_GOOD, 8'h00);
    cmd(rsw_pkg::OP_QDLY, 0, 0, rsw_pkg::RC_GOOD, 8'h08);
    for (int i = 0; i < 8; i++) rb(i, 8'(i + 1));
    cmd(rsw_pkg::OP_FORCE, 32'h1, 0, rsw_pkg::RC_GOOD, 8'h00);
    chk({msel, dsel}, 2'h2);
    cmd(rsw_pkg::OP_FORCE, 32'h200, 0, rsw_pkg::RC_BPAR, 8'h00);
    chk({msel, dsel}, 2'h2);
    cfg <= 2'h1;
    repeat (6) @(posedge clk);
    cmd(rsw_pkg::OP_QSTAT, 0, 0, rsw_pkg::RC_GOOD, 8'h02);
    rb(0, 8'h01);
    rb(1, 8'h02);
    cfg <= 2'h3;
  endtask
  task automatic t_fdef();
    logic [63:0] v;
    v = {rsw_pkg::DEF_DMF, rsw_pkg::DEF_DMN, rsw_pkg::DEF_DDF,
         rsw_pkg::DEF_DDN};
    cmd(rsw_pkg::OP_FDEF, 32'h5555, 0, rsw_pkg::RC_BPAR, 8'h00);
    chk(msel, 1'b1);
    cmd(rsw_pkg::OP_FDEF, 32'hAA55, 0, rsw_pkg::RC_GOOD, 8'h00);
    chk(msel, 1'b0);
    cmd(rsw_pkg::OP_QDLY, 0, 0, rsw_pkg::RC_GOOD, 8'h08);
    for (int i = 0; i < 8; i++) rb(i, v[63-8*i -: 8]);
  endtask
  task automatic t_alarm();
    sal <= 5'h04;
    repeat (8) @(posedge clk);
    cmd(rsw_pkg::OP_QALM, 0, 0, rsw_pkg::RC_GOOD, 8'h05);
    rb(0, 8'h01);
    rb(1, 8'h00);
    rb(2, 8'h04);
    rb(3, 8'h00);
    rb(4, 8'h00);
    chk(galarm, 1'b1);
    wr(rsw_pkg::A_AMASK, 32'h0000FBFF);
    repeat (4) @(posedge clk);
    chk(galarm, 1'b0);
    cmd(rsw_pkg::OP_QMSK, 0, 0, rsw_pkg::RC_GOOD, 8'h04);
    rb(0, 8'hFF);
    rb(1, 8'h1B);
    rb(2, 8'h00);
    rb(3, 8'h00);
    fal <= 4'h2;
    repeat (8) @(posedge clk);
    chk(galarm, 1'b1);
    rd(rsw_pkg::A_ALARM);
    chk(r[15:8], 8'h08);
    wr(rsw_pkg::A_AMASK, 32'h00001BF7);
    repeat (4) @(posedge clk);
    chk(galarm, 1'b0);
    fal <= 4'h0;
    sal <= 5'h00;
  endtask
  task automatic t_filt();
    // ten ticks each way, far from the sync and tick phase slack
    cmd(rsw_pkg::OP_SDLY, 32'h0A000A00, 32'h0A000A00,
        rsw_pkg::RC_GOOD, 8'h00);
    cmd(rsw_pkg::OP_SMODE, 32'h1, 0, rsw_pkg::RC_GOOD, 8'h00);
    uflt <= 4'h1;
    ext0(20, 1'b0);
    ext0(60, 1'b1);
    chk(msel, 1'b1);
    uflt <= 4'h0;
    ext0(20, 1'b1);
    ext0(60, 1'b0);
  endtask
  task automatic t_irq();
    rd(rsw_pkg::A_ISTAT);
    chk(r[2:0], 3'h7);
    wr(rsw_pkg::A_ISTAT, 32'h7);
    wr(rsw_pkg::A_IMASK, 32'h1);
    cmd(rsw_pkg::OP_ID, 0, 0, rsw_pkg::RC_GOOD, 8'h01);
    @(posedge clk);
    chk(irq, 1'b1);
    wr(rsw_pkg::A_ISTAT, 32'h1);
    @(posedge clk);
    chk(irq, 1'b0);
    wr(rsw_pkg::A_IMASK, 32'h0);
    cmd(rsw_pkg::OP_ID, 0, 0, rsw_pkg::RC_GOOD, 8'h01);
    @(posedge clk);
    chk(irq, 1'b0);
    rd(rsw_pkg::A_ISTAT);
    chk(r[0], 1'b1);
    wr(rsw_pkg::A_ISTAT, 32'h7);
    cmd(rsw_pkg::OP_FORCE, 32'h100, 0, rsw_pkg::RC_GOOD, 8'h00);
    chk({msel, dsel}, 2'h1);
    rd(rsw_pkg::A_ISTAT);
    chk(r[2:0], 3'h5);
    rd(12'h020);
    chk(r, 32'h0);
    chk(e, 1'b1);
  endtask
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    uflt = 4'h0;
    fal = 4'h0;
    sal = 5'h00;
    cfg = 2'h0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    t_query();
    t_set();
    t_fdef();
    t_alarm();
    t_filt();
    t_irq();
    report_and_stop();
  end
endmodule
